// >>> lin_mode_cfg.svh
// offsets, bit positions, reset values and counts for the LIN-mode block
`ifndef LIN_MODE_CFG_SVH
`define LIN_MODE_CFG_SVH

`define OFS_STATUS 5'h00
`define OFS_CTRL2 5'h04
`define OFS_CTRL3 5'h08
`define OFS_MANT 5'h0c
`define OFS_RXPRE 5'h10
`define OFS_TXPRE 5'h14

`define CR2_MUTE 1
`define CR2_BRK 0
`define CR3_DUM 7
`define CR3_LINE 6
`define CR3_SLV 5
`define CR3_ASE 4
`define CR3_HDM 3
`define CR3_HIE 2
`define CR3_HDF 1
`define CR3_SYNCH 0
`define ST_RXFULL 5

`define REG_RESET 8'h00
`define BRK_SLAVE_BITS 11
`define BRK_MASTER_BITS 13
`define BRK_SCI_BITS 10
`define OVERSAMPLE 16
`define QTR_PER_BIT 4
`define HDR_MAX_BITS 57
`define HL_BREAK 8'hff
`define HL_TIMEOUT 8'h00
`define SYNC_EDGES 5

`endif

// >>> lin_mode_pkg.sv
// types shared by the LIN-mode block
package lin_mode_pkg;

   typedef enum logic [1:0] {
      HDR_IDLE = 2'b00,
      HDR_SYNCH = 2'b01,
      HDR_IDENT = 2'b10
   } hdr_state_t;

   typedef enum logic {
      BRK_IDLE = 1'b0,
      BRK_LOW = 1'b1
   } brk_state_t;

endpackage

// >>> frac_baud_gen.sv
// fractional divider: one sample tick per divider/16 clocks, bit tick per 16
`timescale 1ns/100ps
`include "lin_mode_cfg.svh"
module frac_baud_gen
#(
   parameter int DIV_W = 12
)
(
   input logic clk,
   input logic rst_b,
   input logic en,
   input logic [DIV_W-1:0] divider,
   output logic sample_tick_q,
   output logic bit_tick_q
);
   logic [DIV_W:0] acc_q;
   logic [DIV_W:0] acc_d;
   logic [3:0] sub_q;

   // divider is in 1/16 units, so adding 16 per clock gives one tick per divider/16
   assign acc_d = acc_q + (DIV_W+1)'(`OVERSAMPLE);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_q <= '0;
         sample_tick_q <= 1'b0;
      end
      else if (!en)
      begin
         acc_q <= '0;
         sample_tick_q <= 1'b0;
      end
      else if (acc_d >= {1'b0, divider})
      begin
         acc_q <= acc_d - {1'b0, divider};
         sample_tick_q <= 1'b1;
      end
      else
      begin
         acc_q <= acc_d;
         sample_tick_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sub_q <= 4'h0;
         bit_tick_q <= 1'b0;
      end
      else
      begin
         if (sample_tick_q)
         begin
            sub_q <= sub_q + 4'h1;
         end
         bit_tick_q <= sample_tick_q && (sub_q == 4'hf);
      end
   end
endmodule // frac_baud_gen

// >>> break_sender.sv
// holds the line low for a given number of bit times
`timescale 1ns/100ps
module break_sender
   import lin_mode_pkg::*;
(
   input logic clk,
   input logic rst_b,
   input logic start,
   input logic bit_tick,
   input logic [3:0] bits,
   output logic busy_q
);
   brk_state_t state_q;
   logic [3:0] cnt_q;
   logic armed_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= BRK_IDLE;
         cnt_q <= 4'h0;
         armed_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            BRK_IDLE:
            begin
               if (start)
               begin
                  state_q <= BRK_LOW;
                  cnt_q <= bits;
                  armed_q <= 1'b0;
               end
            end
            BRK_LOW:
            begin
               if (bit_tick && !armed_q)
               begin
                  armed_q <= 1'b1;
               end
               else if (bit_tick)
               begin
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1)
                  begin
                     state_q <= BRK_IDLE;
                  end
               end
            end
            default:
            begin
               state_q <= BRK_IDLE;
            end
         endcase
      end
   end

   // low only from a bit boundary, so the break is whole bit times long
   assign busy_q = (state_q == BRK_LOW) && armed_q;
endmodule // break_sender

// >>> lin_mode_control.sv
// LIN-mode control: register slave, break send, header and synch tracking
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`include "lin_mode_cfg.svh"
module lin_mode_control
   import lin_mode_pkg::*;
#(
   parameter int SYNC_CNT_W = 16
)
(
   input logic clk,
   input logic rst_b,
   input logic [4:0] address,
   input logic read,
   input logic write,
   input logic [31:0] writedata,
   input logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input logic rx_pin,
   input logic rx_full_flag,
   input logic tx_data_in,
   input logic tx_busy_in,
   input logic wake_in,
   output logic tx_pin,
   output logic mute_control,
   output logic slave_mode,
   output logic header_irq,
   output logic sample_tick
);
   localparam logic [7:0] BRK_SAMPLES = 8'(`BRK_SLAVE_BITS * `OVERSAMPLE);
   localparam logic [7:0] QTR_MAX = 8'(`HDR_MAX_BITS * `QTR_PER_BIT);
   localparam logic [7:0] QTR_AT_BRK = 8'(`BRK_SLAVE_BITS * `QTR_PER_BIT);

   function automatic logic [7:0] hdr_code(input logic [7:0] qtr);
      return QTR_MAX - qtr;
   endfunction

   logic waitrequest_q;
   logic [31:0] readdata_q;
   logic [7:0] rd_mux;
   logic wr_go;
   logic rd_go;
   logic sel_st;
   logic sel2;
   logic sel3;
   logic sel_mant;
   logic sel_rxp;
   logic sel_txp;
   logic [7:0] wd;

   logic [5:0] ctrl2_hi_q;
   logic mute_q;
   logic brk_q;
   logic brk_pend_q;
   logic dum_q;
   logic line_q;
   logic slv_q;
   logic ase_q;
   logic hdm_q;
   logic hie_q;
   logic hdf_q;
   logic synch_state_q;
   logic arm_q;
   logic slave;

   logic [7:0] mant_q;
   logic [3:0] frac_q;
   logic [11:0] eff_div_q;
   logic [7:0] brr_q;
   logic [7:0] erpr_q;
   logic [7:0] etpr_q;
   logic [7:0] hl_q;

   logic rxf_q;
   logic rxf_rise;
   logic rx_prev_q;
   logic rx_fall;
   logic [7:0] low_cnt_q;
   logic brk_det;
   hdr_state_t hdr_q;
   logic [7:0] qtr_q;
   logic [1:0] qsub_q;
   logic timeout;
   logic sync_done;
   logic id_done;
   logic hdr_set;
   logic synch_sw_clr;
   logic [2:0] edge_q;
   logic [SYNC_CNT_W-1:0] sc_q;
   logic autosync_load;
   logic wake;

   logic bit_tick;
   logic samp;
   logic brk_start;
   logic brk_busy;
   logic tx_q;
   logic mute_out_q;
   logic slave_out_q;
   logic irq_q;

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign tx_pin = tx_q;
   assign mute_control = mute_out_q;
   assign slave_mode = slave_out_q;
   assign header_irq = irq_q;

   assign slave = line_q & slv_q;
   assign wd = writedata[7:0];

   // one wait state: request taken when waitrequest is low
   assign wr_go = write & ~waitrequest_q & byteenable[0];
   assign rd_go = read & ~waitrequest_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waitrequest_q <= 1'b1;
      end
      else
      begin
         waitrequest_q <= ~((read | write) & waitrequest_q);
      end
   end

   always_comb
   begin
      sel_st = 1'b0;
      sel2 = 1'b0;
      sel3 = 1'b0;
      sel_mant = 1'b0;
      sel_rxp = 1'b0;
      sel_txp = 1'b0;
      if (address == `OFS_STATUS)
      begin
         sel_st = 1'b1;
      end
      else if (address == `OFS_CTRL2)
      begin
         sel2 = 1'b1;
      end
      else if (address == `OFS_CTRL3)
      begin
         sel3 = 1'b1;
      end
      else if (address == `OFS_MANT)
      begin
         sel_mant = 1'b1;
      end
      else if (address == `OFS_RXPRE)
      begin
         sel_rxp = 1'b1;
      end
      else if (address == `OFS_TXPRE)
      begin
         sel_txp = 1'b1;
      end
   end

   always_comb
   begin
      rd_mux = 8'h00;
      if (sel_st)
      begin
         rd_mux[`ST_RXFULL] = rx_full_flag;
      end
      else if (sel2)
      begin
         rd_mux = {ctrl2_hi_q, mute_q, brk_q};
      end
      else if (sel3)
      begin
         rd_mux = {dum_q, line_q, slv_q, ase_q, hdm_q, hie_q, hdf_q, synch_state_q};
      end
      else if (sel_mant)
      begin
         rd_mux = slave ? eff_div_q[11:4] : brr_q;
      end
      else if (sel_rxp)
      begin
         if (!slave)
         begin
            rd_mux = erpr_q;
         end
         else if (ase_q | hdm_q)
         begin
            rd_mux = hl_q;
         end
      end
      else if (sel_txp)
      begin
         rd_mux = slave ? {4'h0, eff_div_q[3:0]} : etpr_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         readdata_q <= 32'h0000_0000;
      end
      else if (read & waitrequest_q)
      begin
         readdata_q <= {24'h00_0000, rd_mux};
      end
   end

   // control two
   assign wake = slave ? hdr_set : wake_in;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl2_hi_q <= 6'h00;
         brk_q <= 1'b0;
         mute_q <= 1'b0;
      end
      else
      begin
         if (wr_go && sel2)
         begin
            ctrl2_hi_q <= wd[7:2];
            brk_q <= wd[`CR2_BRK];
         end
         if (wake)
         begin
            mute_q <= 1'b0;
         end
         else if (wr_go && sel2 && !(slave && rx_full_flag))
         begin
            mute_q <= wd[`CR2_MUTE];
         end
      end
   end

   // a set that is cleared before the word ends still leaves one break owed
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         brk_pend_q <= 1'b0;
      end
      else if (wr_go && sel2 && wd[`CR2_BRK] && !slave)
      begin
         brk_pend_q <= 1'b1;
      end
      else if (brk_start)
      begin
         brk_pend_q <= 1'b0;
      end
   end

   assign brk_start = !slave && (brk_q || brk_pend_q) && !tx_busy_in && !brk_busy;

   // control three
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         line_q <= 1'b0;
         slv_q <= 1'b0;
         ase_q <= 1'b0;
         hdm_q <= 1'b0;
         hie_q <= 1'b0;
      end
      else if (wr_go && sel3)
      begin
         line_q <= wd[`CR3_LINE];
         slv_q <= wd[`CR3_SLV];
         ase_q <= wd[`CR3_ASE];
         hdm_q <= wd[`CR3_HDM];
         hie_q <= wd[`CR3_HIE];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dum_q <= 1'b0;
      end
      else if (wr_go && sel3)
      begin
         dum_q <= wd[`CR3_DUM];
      end
      else if (rxf_rise)
      begin
         dum_q <= 1'b0;
      end
   end

   // status access arms the flag clear; the set wins over the clear
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arm_q <= 1'b0;
      end
      else if ((rd_go || wr_go) && sel_st)
      begin
         arm_q <= 1'b1;
      end
      else if (rd_go && sel3)
      begin
         arm_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hdf_q <= 1'b0;
      end
      else if (hdr_set)
      begin
         hdf_q <= 1'b1;
      end
      else if (rd_go && sel3 && arm_q)
      begin
         hdf_q <= 1'b0;
      end
   end

   assign synch_sw_clr = wr_go && sel3 && !wd[`CR3_SYNCH];

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         synch_state_q <= 1'b0;
      end
      else if (brk_det)
      begin
         synch_state_q <= 1'b1;
      end
      else if (sync_done || timeout || synch_sw_clr)
      begin
         synch_state_q <= 1'b0;
      end
   end

   // divider: pending values and the effective one
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mant_q <= `REG_RESET;
         frac_q <= 4'h0;
         brr_q <= `REG_RESET;
         erpr_q <= `REG_RESET;
         etpr_q <= `REG_RESET;
      end
      else if (wr_go && slave)
      begin
         if (sel_mant)
         begin
            mant_q <= wd;
         end
         if (sel_txp)
         begin
            frac_q <= wd[3:0];
         end
      end
      else if (wr_go)
      begin
         if (sel_mant)
         begin
            brr_q <= wd;
         end
         if (sel_rxp)
         begin
            erpr_q <= wd;
         end
         if (sel_txp)
         begin
            etpr_q <= wd;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         eff_div_q <= 12'h000;
      end
      else if (autosync_load)
      begin
         eff_div_q <= 12'(sc_q >> 3);
      end
      else if (wr_go && slave && sel_mant && !dum_q)
      begin
         eff_div_q <= {wd, frac_q};
      end
      else if (rxf_rise && slave && dum_q)
      begin
         eff_div_q <= {mant_q, frac_q};
      end
   end

   frac_baud_gen #(
      .DIV_W(12)
   ) u_baud (
      .clk(clk),
      .rst_b(rst_b),
      .en(eff_div_q[11:4] != 8'h00),
      .divider(eff_div_q),
      .sample_tick_q(samp),
      .bit_tick_q(bit_tick)
   );

   break_sender u_brk (
      .clk(clk),
      .rst_b(rst_b),
      .start(brk_start),
      .bit_tick(bit_tick),
      .bits(line_q ? 4'(`BRK_MASTER_BITS) : 4'(`BRK_SCI_BITS)),
      .busy_q(brk_busy)
   );

   // receive side: edges, break detection, header walk
   assign rxf_rise = rx_full_flag & ~rxf_q;
   assign rx_fall = rx_prev_q & ~rx_pin;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rxf_q <= 1'b0;
         rx_prev_q <= 1'b1;
         low_cnt_q <= 8'h00;
      end
      else
      begin
         rxf_q <= rx_full_flag;
         rx_prev_q <= rx_pin;
         if (rx_pin)
         begin
            low_cnt_q <= 8'h00;
         end
         else if (samp && low_cnt_q != BRK_SAMPLES)
         begin
            low_cnt_q <= low_cnt_q + 8'h01;
         end
      end
   end

   assign brk_det = slave && samp && !rx_pin && low_cnt_q == BRK_SAMPLES - 8'h01;
   assign timeout = (hdr_q != HDR_IDLE) && qtr_q >= QTR_MAX;
   assign autosync_load = ase_q && slave && hdr_q == HDR_SYNCH && rx_fall
      && edge_q == 3'(`SYNC_EDGES - 1);
   assign sync_done = hdr_q == HDR_SYNCH && (ase_q ? autosync_load : rxf_rise);
   assign id_done = hdr_q == HDR_IDENT && rxf_rise;
   assign hdr_set = (brk_det && !hdm_q) || (slave && id_done && hdm_q);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hdr_q <= HDR_IDLE;
      end
      else if (brk_det)
      begin
         hdr_q <= HDR_SYNCH;
      end
      else if (timeout || !slave)
      begin
         hdr_q <= HDR_IDLE;
      end
      else
      begin
         case (hdr_q)
            HDR_SYNCH:
            begin
               if (synch_sw_clr)
               begin
                  hdr_q <= HDR_IDLE;
               end
               else if (sync_done)
               begin
                  hdr_q <= HDR_IDENT;
               end
            end
            HDR_IDENT:
            begin
               if (id_done)
               begin
                  hdr_q <= HDR_IDLE;
               end
            end
            default:
            begin
               hdr_q <= HDR_IDLE;
            end
         endcase
      end
   end

   // auto-sync: clock cycles from first to fifth falling edge span 8 bits
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         edge_q <= 3'h0;
         sc_q <= '0;
      end
      else if (hdr_q != HDR_SYNCH || !ase_q)
      begin
         edge_q <= 3'h0;
         sc_q <= '0;
      end
      else
      begin
         if (rx_fall)
         begin
            edge_q <= edge_q + 3'h1;
         end
         if (edge_q != 3'h0 && sc_q != '1)
         begin
            sc_q <= sc_q + 1'b1;
         end
      end
   end

   // header duration counted in quarter bits, break already 11 bits long
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         qtr_q <= 8'h00;
         qsub_q <= 2'h0;
      end
      else if (brk_det)
      begin
         qtr_q <= QTR_AT_BRK;
         qsub_q <= 2'h0;
      end
      else if (hdr_q != HDR_IDLE && samp)
      begin
         qsub_q <= qsub_q + 2'h1;
         if (qsub_q == 2'h3)
         begin
            qtr_q <= qtr_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hl_q <= `REG_RESET;
      end
      else if (brk_det)
      begin
         hl_q <= `HL_BREAK;
      end
      else if (timeout)
      begin
         hl_q <= `HL_TIMEOUT;
      end
      else if (slave && id_done && hdm_q)
      begin
         hl_q <= hdr_code(qtr_q);
      end
   end

   // registered outputs
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_q <= 1'b1;
         mute_out_q <= 1'b0;
         slave_out_q <= 1'b0;
         irq_q <= 1'b0;
         sample_tick <= 1'b0;
      end
      else
      begin
         tx_q <= brk_busy ? 1'b0 : tx_data_in;
         mute_out_q <= mute_q;
         slave_out_q <= slave;
         irq_q <= slave && hie_q && hdf_q;
         sample_tick <= samp;
      end
   end
endmodule // lin_mode_control

// >>> lin_node_model.sv
// far-side LIN node: holds the shared line dominant for a set span
`timescale 1ns/100ps
module lin_node_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [15:0] low_len,
   output logic line
);
   logic [15:0] cnt_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= 16'h0;
      else if (start)
         cnt_q <= low_len;
      else if (cnt_q != 16'h0)
         cnt_q <= cnt_q - 16'h1;
   end
   // bus pull-up: recessive high whenever this node lets go
   assign line = (cnt_q == 16'h0);
endmodule // lin_node_model

// >>> lin_mode_control_asserts.sv
// port-level checks for the LIN-mode block
`timescale 1ns/100ps
`include "lin_mode_cfg.svh"
module lin_mode_control_asserts
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic waitrequest,
   input wire logic rx_full_flag,
   input wire logic tx_data_in,
   input wire logic wake_in,
   input wire logic tx_pin,
   input wire logic mute_control,
   input wire logic slave_mode,
   input wire logic header_irq,
   input wire logic sample_tick
);
   logic acc;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   assign acc = write && !waitrequest && byteenable[0];
   a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer one cycle after request");
   a_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_idle_wait: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest low without request");
   a_tx_follow: assert property (!$past(tx_data_in) |-> !tx_pin)
      else $error("tx pin high while data was low");
   a_mute_source: assert property ($rose(mute_control) |->
      $past(acc && address == `OFS_CTRL2 && writedata[1], 2))
      else $error("mute set without a write");
   a_mute_locked: assert property (acc && address == `OFS_CTRL2 && slave_mode
      && rx_full_flag && !wake_in |=> ##1 $stable(mute_control))
      else $error("mute changed while receive full");
   a_mode_source: assert property ($changed(slave_mode) |->
      $past(acc && address == `OFS_CTRL3, 2))
      else $error("slave mode changed without a write");
   a_irq_slave: assert property (header_irq |-> slave_mode)
      else $error("header interrupt outside slave mode");
   a_clock_stop: assert property (acc && address == `OFS_MANT && slave_mode
      && writedata[7:0] == 8'h00 |-> ##4 !sample_tick [*8])
      else $error("sample tick with zero mantissa");
   c_break: cover property ($fell(tx_pin));
   c_irq: cover property ($rose(header_irq));
   c_mant: cover property (acc && address == `OFS_MANT && slave_mode);
endmodule // lin_mode_control_asserts
bind lin_mode_control lin_mode_control_asserts u_chk (.clk(clk), .rst_b(rst_b),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .waitrequest(waitrequest), .rx_full_flag(rx_full_flag),
   .tx_data_in(tx_data_in), .wake_in(wake_in), .tx_pin(tx_pin),
   .mute_control(mute_control), .slave_mode(slave_mode), .header_irq(header_irq),
   .sample_tick(sample_tick));

// >>> lin_mode_control_tb_top.sv
// self-checking bench for the LIN-mode block
`timescale 1ns/100ps
`include "lin_mode_cfg.svh"
module lin_mode_control_tb_top;
   logic clk, rst_b, read, write, rx_full_flag, tx_data_in, tx_busy_in, wake_in;
   logic [4:0] address;
   logic [31:0] writedata, readdata, seed_q;
   logic [3:0] byteenable;
   logic waitrequest, tx_pin, mute_control, slave_mode, header_irq, sample_tick;
   logic rx_line, pstart;
   logic [15:0] plen;
   logic [7:0] rd;
   int n_errors, n_tests, ticks, d, t0, t1;
   int cyc = 0;
   lin_mode_control u_dut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .rx_pin(rx_line),
      .rx_full_flag(rx_full_flag), .tx_data_in(tx_data_in), .tx_busy_in(tx_busy_in),
      .wake_in(wake_in), .tx_pin(tx_pin), .mute_control(mute_control),
      .slave_mode(slave_mode), .header_irq(header_irq), .sample_tick(sample_tick));
   lin_node_model u_node (.clk(clk), .rst_b(rst_b), .start(pstart), .low_len(plen),
      .line(rx_line));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // master side: hold the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v);
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, v};
      write <= wr;
      read <= !wr;
      // no cycle count assumed: only the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
      end
      while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rd, exp);
   endtask
   task automatic send_low(input logic [15:0] len);
      pstart <= 1'b1;
      plen <= len;
      @(posedge clk);
      pstart <= 1'b0;
      repeat (int'(len) + 4) @(posedge clk);
   endtask
   task automatic pulse_full;
      rx_full_flag <= 1'b1;
      repeat (3) @(posedge clk);
      rx_full_flag <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic count_ticks(input int n);
      ticks = 0;
      repeat (n)
      begin
         @(posedge clk);
         ticks += int'(sample_tick);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      $display("[ERR] t=%0t watchdog expired", $time);
      n_errors++;
      print_verdict;
   end
   initial
   begin
      {rst_b, read, write, rx_full_flag, tx_busy_in, wake_in, pstart} = 7'h0;
      tx_data_in = 1'b1;
      address = 5'h0;
      writedata = 32'h0;
      byteenable = 4'hf;
      plen = 16'h0;
      seed_q = 32'hd4fe;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 32; a += 4)
         rchk(5'(a), 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 4; i++)
      begin
         seed_q = lfsr(seed_q);
         tx_data_in <= seed_q[3];
         bus(1'b1, `OFS_CTRL2, seed_q[7:0] & 8'hfe);
         rchk(`OFS_CTRL2, seed_q[7:0] & 8'hfe);
         check(mute_control, seed_q[1]);
         check(tx_pin, seed_q[3]);
      end
      tx_data_in <= 1'b1;
      bus(1'b1, `OFS_CTRL2, 8'h02);
      wake_in <= 1'b1;
      @(posedge clk);
      wake_in <= 1'b0;
      repeat (3) @(posedge clk);
      check(mute_control, 1'b0);
      byteenable <= 4'h0;
      bus(1'b1, `OFS_CTRL2, 8'h02);
      byteenable <= 4'hf;
      rchk(`OFS_CTRL2, 8'h00);
      $display("test mute control done");
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, `OFS_CTRL3, 8'(i << 5));
         repeat (2) @(posedge clk);
         check(slave_mode, i == 3);
      end
      $display("test mode select done");
      bus(1'b1, `OFS_TXPRE, 8'hab);
      rchk(`OFS_TXPRE, 8'h00);
      bus(1'b1, `OFS_MANT, 8'h02);
      rchk(`OFS_MANT, 8'h02);
      rchk(`OFS_TXPRE, 8'h0b);
      bus(1'b1, `OFS_TXPRE, 8'h00);
      bus(1'b1, `OFS_MANT, 8'h02);
      bus(1'b1, `OFS_CTRL3, 8'he0);
      bus(1'b1, `OFS_MANT, 8'h05);
      rchk(`OFS_MANT, 8'h02);
      rx_full_flag <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(`OFS_MANT, 8'h05);
      rchk(`OFS_CTRL3, 8'h60);
      bus(1'b1, `OFS_CTRL2, 8'h02);
      rchk(`OFS_CTRL2, 8'h00);
      rx_full_flag <= 1'b0;
      bus(1'b1, `OFS_MANT, 8'h02);
      $display("test divider update done");
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, `OFS_CTRL3, i == 0 ? 8'h40 : i == 1 ? 8'h00 : 8'h60);
         bus(1'b1, `OFS_CTRL2, 8'h01);
         bus(1'b1, `OFS_CTRL2, 8'h00);
         ticks = 0;
         d = 0;
         while (tx_pin !== 1'b0 && d < 300)
         begin
            @(posedge clk);
            d++;
         end
         count_ticks(0);
         while (tx_pin === 1'b0 && d < 3000)
         begin
            @(posedge clk);
            d++;
            ticks += int'(sample_tick);
         end
         check((ticks + 8) / 16, i == 0 ? 13 : i == 1 ? 10 : 0);
         repeat (1500) @(posedge clk);
      end
      $display("test break send done");
      bus(1'b1, `OFS_CTRL3, 8'h64);
      send_low(16'd300);
      rchk(`OFS_CTRL3, 8'h64);
      send_low(16'd600);
      rchk(`OFS_CTRL3, 8'h67);
      check(header_irq, 1'b1);
      rchk(`OFS_RXPRE, 8'h00);
      rchk(`OFS_STATUS, 8'h00);
      rchk(`OFS_CTRL3, 8'h67);
      rchk(`OFS_CTRL3, 8'h65);
      repeat (2) @(posedge clk);
      check(header_irq, 1'b0);
      bus(1'b1, `OFS_CTRL3, 8'h64);
      rchk(`OFS_CTRL3, 8'h64);
      $display("test break header done");
      bus(1'b1, `OFS_CTRL3, 8'h6c);
      t0 = cyc;
      send_low(16'd600);
      rchk(`OFS_RXPRE, 8'hff);
      rchk(`OFS_CTRL3, 8'h6d);
      pulse_full;
      rchk(`OFS_CTRL3, 8'h6c);
      t1 = cyc;
      pulse_full;
      rchk(`OFS_CTRL3, 8'h6e);
      // quarter bit is eight clocks with a divider of two
      bus(1'b0, `OFS_RXPRE, 8'h00);
      check(rd === `HL_BREAK, 1'b0);
      d = int'(rd) - (228 - (t1 - t0) / 8);
      check(d >= -3 && d <= 3, 1);
      $display("test identifier header done");
      bus(1'b1, `OFS_MANT, 8'h00);
      // ticks already launched before the write still drain out
      repeat (4) @(posedge clk);
      count_ticks(100);
      check(ticks, 0);
      bus(1'b1, `OFS_MANT, 8'h02);
      repeat (10) @(posedge clk);
      count_ticks(64);
      check(ticks, 32);
      $display("test clock stop done");
      print_verdict;
   end
endmodule // lin_mode_control_tb_top
